// File: rtl/bsap_port.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Sample FIFO between the user side and the serial transmitter
module bsap_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Extra pointer bit tells full from empty
	assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];

	// Storage has no reset; only the pointers need it
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	// Pointer update
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= push ? (AW+1)'(wr_ptr + 1'b1) : wr_ptr;
			rd_ptr <= pop ? (AW+1)'(rd_ptr + 1'b1) : rd_ptr;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Master drives clock and select; slave receives them
// - Serial data output always driven
// - Each channel sample is 16 bits
// - MSB first, aligned to slot start
// - MSB one bit clock after select change
// - Output data changes only on falling edges
// - Left while select low, right while high
// - Master short frame: 32 clocks, 1.536 MHz
// - Master long frame: 50 clocks, 2.400 MHz
// - Master clock from fractional N/M divider
// - Slave accepts any rate up to 3.072 MHz
// - Master clock phases at least 0.35T
module bsap_port #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic master,
	input wire logic rate_long,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic ws_in,
	output logic ws_out,
	output logic ws_oe,
	output logic sdo,
	input wire logic sdi,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire bsap_pkg::bsap_frame_type tx_data,
	output logic rx_valid,
	output bsap_pkg::bsap_frame_type rx_data
);
	logic [bsap_pkg::ACC_W-1:0] acc;
	logic sck_gen;
	logic ws_gen;
	logic [bsap_pkg::CNT_W-1:0] fcnt;
	logic sck_s;
	logic sck_p;
	logic ws_s;
	logic ws_rise;
	logic start_pend;
	bsap_pkg::bsap_tx_type tx_state;
	logic [4:0] tx_cnt;
	logic [bsap_pkg::SAMPLE_BITS-1:0] tx_shift;
	logic [bsap_pkg::SAMPLE_BITS-1:0] tx_right;
	logic [4:0] rx_cnt;
	logic rx_chan;
	logic [bsap_pkg::SAMPLE_BITS-1:0] rx_shift;
	logic [bsap_pkg::SAMPLE_BITS-1:0] rx_left;
	logic fifo_valid;
	bsap_pkg::bsap_frame_type fifo_data;

	////////////////////////////////////////////////////////////////////////////
	// Fractional divider: adds N each cycle, wraps at M, toggles clock on wrap
	wire [bsap_pkg::ACC_W-1:0] div_n = rate_long ? bsap_pkg::DIV_N_LONG : bsap_pkg::DIV_N_SHORT;
	wire [bsap_pkg::ACC_W-1:0] acc_sum = bsap_pkg::ACC_W'(acc + div_n);
	wire div_wrap = master && (acc_sum >= bsap_pkg::DIV_M);
	wire [bsap_pkg::CNT_W-1:0] last_bit = rate_long ? bsap_pkg::LAST_LONG : bsap_pkg::LAST_SHORT;
	wire [bsap_pkg::CNT_W-1:0] half_bit = rate_long ? bsap_pkg::HALF_LONG : bsap_pkg::HALF_SHORT;
	wire [bsap_pkg::CNT_W-1:0] next_fcnt = (fcnt == last_bit) ? '0 : bsap_pkg::CNT_W'(fcnt + 1'b1);

	// Wraps land every 3 or 4 reference cycles at the short rate and 2 or 3 at the long, so both phases stay near half
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc <= '0;
			sck_gen <= 1'b0;
		end else begin
			acc <= !master ? '0 : (div_wrap ? bsap_pkg::ACC_W'(acc_sum - bsap_pkg::DIV_M) : acc_sum);
			sck_gen <= div_wrap ? !sck_gen : sck_gen;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Edge events; slave pins are sampled once, previous value kept for edges
	wire rise_evt = master ? (div_wrap && !sck_gen) : (sck_s && !sck_p);
	wire fall_evt = master ? (div_wrap && sck_gen) : (!sck_s && sck_p);
	wire ws_line = master ? ws_gen : ws_s;
	wire ws_change = rise_evt && (ws_line != ws_rise);

	// Slave edges need only one sample per phase, so rates to 3.072 MHz work
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sck_s <= 1'b0;
			sck_p <= 1'b0;
			ws_s <= 1'b0;
		end else begin
			sck_s <= sck_in;
			sck_p <= sck_s;
			ws_s <= ws_in;
		end
	end

	// Frame counter and select; select moves only with a falling edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fcnt <= '0;
			ws_gen <= 1'b0;
		end else if (!master) begin
			fcnt <= '0;
			ws_gen <= 1'b0;
		end else if (fall_evt) begin
			fcnt <= next_fcnt;
			ws_gen <= next_fcnt >= half_bit;
		end
	end

	// Pin drivers: direction follows the mode, data out is always driven
	assign sck_out = sck_gen;
	assign ws_out = ws_gen;
	assign sck_oe = master;
	assign ws_oe = master;

	////////////////////////////////////////////////////////////////////////////
	// Select change seen at a rising edge starts a slot at the next falling one
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ws_rise <= 1'b0;
			start_pend <= 1'b0;
		end else begin
			ws_rise <= rise_evt ? ws_line : ws_rise;
			start_pend <= ws_change || (start_pend && !fall_evt);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit: a stereo pair is taken at each left slot; empty FIFO sends zero
	wire slot_start = fall_evt && start_pend;
	wire tx_pop = slot_start && !ws_rise && fifo_valid;
	wire [bsap_pkg::SAMPLE_BITS-1:0] left_word = fifo_valid ? fifo_data.left : '0;
	wire [bsap_pkg::SAMPLE_BITS-1:0] load_word = ws_rise ? tx_right : left_word;

	bsap_fifo #(
		.WIDTH($bits(bsap_pkg::bsap_frame_type)),
		.DEPTH(FIFO_DEPTH)
	) tx_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(fifo_valid),
		.out_ready(tx_pop),
		.out_data(fifo_data)
	);

	// Shift on falling edges so the far end samples stable data on rising ones
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_state <= bsap_pkg::TX_WAIT;
			tx_cnt <= '0;
			tx_shift <= '0;
			tx_right <= '0;
			sdo <= 1'b0;
		end else if (slot_start) begin
			tx_state <= bsap_pkg::TX_DATA;
			tx_cnt <= bsap_pkg::BITS_AFTER_MSB;
			sdo <= load_word[bsap_pkg::SAMPLE_BITS-1];
			tx_shift <= {load_word[bsap_pkg::SAMPLE_BITS-2:0], 1'b0};
			tx_right <= (!ws_rise && fifo_valid) ? fifo_data.right : (ws_rise ? tx_right : '0);
		end else if (fall_evt) begin
			case (tx_state)
				bsap_pkg::TX_DATA: begin
					sdo <= (tx_cnt != '0) && tx_shift[bsap_pkg::SAMPLE_BITS-1];
					tx_shift <= {tx_shift[bsap_pkg::SAMPLE_BITS-2:0], 1'b0};
					tx_cnt <= (tx_cnt != '0) ? 5'(tx_cnt - 1'b1) : tx_cnt;
					tx_state <= (tx_cnt != '0) ? bsap_pkg::TX_DATA : bsap_pkg::TX_PAD;
				end
				bsap_pkg::TX_PAD: begin
					sdo <= 1'b0;
				end
				default: begin
					sdo <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive: 16 bits after each select change, extra clocks are ignored.
	// In 32-clock frames the rise that shows a select change still carries the old slot's LSB.
	wire rx_take = rise_evt && (rx_cnt != '0);
	wire rx_done = rx_take && (rx_cnt == 5'd1);
	wire [bsap_pkg::SAMPLE_BITS-1:0] rx_word = {rx_shift[bsap_pkg::SAMPLE_BITS-2:0], sdi};

	// A pair is handed out after its right word, both halves from flip-flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_cnt <= '0;
			rx_chan <= 1'b0;
			rx_shift <= '0;
			rx_left <= '0;
			rx_data <= '0;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= rx_done && rx_chan;
			if (rx_take) begin
				rx_shift <= rx_word;
			end
			if (ws_change) begin
				rx_cnt <= 5'(bsap_pkg::SAMPLE_BITS);
				rx_chan <= ws_line;
			end else if (rx_take) begin
				rx_cnt <= 5'(rx_cnt - 1'b1);
			end
			if (rx_done && !rx_chan) begin
				rx_left <= rx_word;
			end
			if (rx_done && rx_chan) begin
				rx_data <= '{left: rx_left, right: rx_word};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking chk_clk @(posedge clock);
	endclocking
	default disable iff (rst);

	// Length of the current clock phase, in reference cycles
	logic [7:0] phase_len;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_len <= '0;
		end else begin
			phase_len <= div_wrap ? 8'd1 : ((phase_len == 8'hFF) ? phase_len : 8'(phase_len + 1'b1));
		end
	end

	sequence slot_load_s;
		slot_start;
	endsequence
	sequence msb_out_s;
		##1 (sdo == $past(load_word[bsap_pkg::SAMPLE_BITS-1]));
	endsequence

	pin_dir_a: assert property (sck_oe == master && ws_oe == master)
		else $error("clock or select direction wrong for mode");
	sdo_edge_a: assert property ($changed(sdo) |-> $past(fall_evt))
		else $error("serial output moved outside a falling edge");
	msb_first_a: assert property (slot_load_s |-> msb_out_s)
		else $error("slot did not open with the sample MSB");
	slot_len_a: assert property (slot_start |=> tx_cnt == bsap_pkg::BITS_AFTER_MSB && tx_state == bsap_pkg::TX_DATA)
		else $error("slot bit count not loaded");
	pad_zero_a: assert property (tx_state == bsap_pkg::TX_PAD && fall_evt && !start_pend |=> !sdo)
		else $error("pad bits not zero");
	ws_fall_a: assert property (master && $changed(ws_gen) |-> $past(fall_evt))
		else $error("select moved outside a falling edge");
	phase_min_a: assert property (master && div_wrap |-> phase_len >= 8'(bsap_pkg::PHASE_MIN_CYC))
		else $error("clock phase too short");
	frame_wrap_a: assert property (master && fall_evt && fcnt == last_bit |=> fcnt == '0 && !ws_gen)
		else $error("frame did not wrap to left slot");
	pop_left_a: assert property (tx_pop |-> !ws_rise ##1 tx_shift[bsap_pkg::SAMPLE_BITS-1] == $past(fifo_data.left[bsap_pkg::SAMPLE_BITS-2]))
		else $error("pair popped outside left slot");
endmodule

// File: rtl/bsap_pkg.sv
package bsap_pkg;
	// Sample and frame geometry
	localparam int SAMPLE_BITS = 16;
	localparam int FRAME_BITS_SHORT = 32;
	localparam int FRAME_BITS_LONG = 50;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] LAST_SHORT = CNT_W'(FRAME_BITS_SHORT - 1);
	localparam logic [CNT_W-1:0] LAST_LONG = CNT_W'(FRAME_BITS_LONG - 1);
	localparam logic [CNT_W-1:0] HALF_SHORT = CNT_W'(FRAME_BITS_SHORT / 2);
	localparam logic [CNT_W-1:0] HALF_LONG = CNT_W'(FRAME_BITS_LONG / 2);
	localparam logic [4:0] BITS_AFTER_MSB = 5'(SAMPLE_BITS - 1);

	// Rates in Hz; the divider steps in units of DIV_SCALE
	localparam int REF_HZ = 10_000_000;
	localparam int BCK_SHORT_HZ = 1_536_000;
	localparam int BCK_LONG_HZ = 2_400_000;
	localparam int SLAVE_MAX_HZ = 3_072_000;
	localparam int DIV_SCALE = 1_000;
	localparam int ACC_W = 15;
	localparam logic [ACC_W-1:0] DIV_M = ACC_W'(REF_HZ / DIV_SCALE);
	localparam logic [ACC_W-1:0] DIV_N_SHORT = ACC_W'(2 * BCK_SHORT_HZ / DIV_SCALE);
	localparam logic [ACC_W-1:0] DIV_N_LONG = ACC_W'(2 * BCK_LONG_HZ / DIV_SCALE);

	// Shortest clock phase allowed, as a fraction 35/100 of the fastest period
	localparam int PHASE_PCT = 35;
	localparam int PHASE_MIN_CYC = (PHASE_PCT * REF_HZ) / (100 * BCK_LONG_HZ) + 1;

	// Stereo sample pair, left first
	typedef struct packed {
		logic [SAMPLE_BITS-1:0] left;
		logic [SAMPLE_BITS-1:0] right;
	} bsap_frame_type;

	// Transmit channel slot state
	typedef enum logic [2:0] {
		TX_WAIT = 3'b001,
		TX_DATA = 3'b010,
		TX_PAD = 3'b100
	} bsap_tx_type;
endpackage

// File: verification/bsap_codec.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Codec model: slave clock source, fixed sdi pair, capture of sdo pairs
module bsap_codec #(
	parameter int HALF = 3
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic run,
	input wire logic sck,
	input wire logic ws,
	input wire logic sdo,
	input wire bsap_pkg::bsap_frame_type send,
	output logic sck_drv,
	output logic ws_drv,
	output logic sdi,
	output logic cap_valid,
	output bsap_pkg::bsap_frame_type cap,
	output logic pad_err
);
	logic sck_q, ws_r, ws_f, pend, fall, rise, slot;
	logic [3:0] ph, ct;
	logic [4:0] gb, next_gb;
	logic [5:0] rc;
	logic [15:0] sh_t, sh_r, left, word;
	// Pin edge events and the word for the slot just begun
	assign fall = sck_q & ~sck;
	assign rise = ~sck_q & sck;
	assign slot = ws != ws_f;
	assign next_gb = gb + 5'h1;
	assign word = ws ? send.right : send.left;

	// Slave clock of 32 bits a frame; it stands still while run is low
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ph <= 4'h0;
			gb <= 5'h0;
			sck_drv <= 1'h0;
			ws_drv <= 1'h0;
		end else if (run) begin
			ph <= (ph == 4'(HALF - 1)) ? 4'h0 : ph + 4'h1;
			if (ph == 4'(HALF - 1)) begin
				sck_drv <= ~sck_drv;
				if (sck_drv) begin
					gb <= next_gb;
					ws_drv <= next_gb[4];
				end
			end
		end
	end

	// Send on falls one bit late, capture on rises; past the word sdi toggles,
	// so a receiver that reads beyond 16 bits is caught
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			{sck_q, ws_r, ws_f, pend, sdi, cap_valid, pad_err} <= 7'h0;
			{sh_t, sh_r, left, cap} <= '0;
			ct <= 4'h0;
			rc <= 6'h3f;
		end else begin
			sck_q <= sck;
			cap_valid <= 1'h0;
			if (fall) begin
				sdi <= pend;
				ws_f <= ws;
				pend <= slot ? word[15] : ((ct != 4'h0) ? sh_t[15] : ~pend);
				sh_t <= slot ? word << 1 : sh_t << 1;
				ct <= slot ? 4'hf : ct - 4'(ct != 4'h0);
			end
			if (rise) begin
				ws_r <= ws;
				rc <= (ws != ws_r) ? 6'h1 : rc + 6'(rc != 6'h3f);
				sh_r <= {sh_r[14:0], sdo};
				if (rc > 6'h10 && rc != 6'h3f && sdo) pad_err <= 1'h1;
				if (rc == 6'h10 && !ws_r) left <= {sh_r[14:0], sdo};
				cap_valid <= rc == 6'h10 && ws_r;
				cap <= {left, sh_r[14:0], sdo};
			end
		end
	end
endmodule

// File: verification/test_bluetooth_audio_serial_port.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Bench: slave fill and drain, then master at both frame lengths
module test_bluetooth_audio_serial_port;
	logic clock = 1'h0;
	logic rst = 1'h1;
	logic master = 1'h0;
	logic rate_long = 1'h0;
	logic run = 1'h0;
	logic tx_valid = 1'h0;
	bsap_pkg::bsap_frame_type tx_data = '0;
	bsap_pkg::bsap_frame_type send = 32'ha5c3_3c5a;
	bsap_pkg::bsap_frame_type rx_data, cap;
	logic sck_out, sck_oe, ws_out, ws_oe, sdo, sdi, tx_ready, rx_valid;
	logic sck_drv, ws_drv, cap_valid, pad_err, pin_sck, pin_ws, b_q, ws_q, sdo_q;
	int fails = 0, samples_checked = 0, cycles = 0, phase = 0, bits = 0, fcyc = 0;
	int nfr = 0, exp_bits = 32;
	bsap_pkg::bsap_frame_type capq[$], rxq[$];

	// Pin levels from whoever holds the enable
	assign pin_sck = sck_oe ? sck_out : sck_drv;
	assign pin_ws = ws_oe ? ws_out : ws_drv;
	always #50 clock = ~clock;

	bsap_port #(.FIFO_DEPTH(8)) DUT (.clock(clock), .rst(rst), .master(master),
		.rate_long(rate_long), .sck_in(pin_sck), .sck_out(sck_out), .sck_oe(sck_oe),
		.ws_in(pin_ws), .ws_out(ws_out), .ws_oe(ws_oe), .sdo(sdo), .sdi(sdi),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.rx_valid(rx_valid), .rx_data(rx_data));
	bsap_codec #(.HALF(3)) codec (.clock(clock), .rst(rst), .run(run), .sck(pin_sck),
		.ws(pin_ws), .sdo(sdo), .send(send), .sck_drv(sck_drv), .ws_drv(ws_drv),
		.sdi(sdi), .cap_valid(cap_valid), .cap(cap), .pad_err(pad_err));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		if (fails == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	function automatic bsap_pkg::bsap_frame_type pat(input int i);
		return 32'h9a5c_0c5a + 32'h0103_0301 * i;
	endfunction

	// Ceiling on run length; reaching it counts as a mismatch
	always @(posedge clock) begin
		cycles++;
		if (cycles > 20000) begin
			fails++;
			close_out();
		end
	end

	// Pin watch; the slave pin is seen a sample late because the port syncs it
	always @(posedge clock) begin
		if (!rst) begin
			if (sdo !== sdo_q) check(master ? pin_sck : b_q, 1'h0);
			if (master && ws_out !== ws_q) check(pin_sck, 1'h0);
			if (master && pin_sck !== b_q) begin
				check(phase >= bsap_pkg::PHASE_MIN_CYC, 1'h1);
				phase = 0;
			end
			if (master && pin_sck && !b_q) bits++;
			if (master && ws_out && !ws_q) begin
				if (nfr > 0) check(bits, exp_bits);
				if (nfr > 0) check(fcyc >= 208 && fcyc <= 209, 1'h1);
				nfr++;
				bits = 0;
				fcyc = 0;
			end
			phase++;
			fcyc++;
		end
		b_q = pin_sck;
		ws_q = ws_out;
		sdo_q = sdo;
		if (cap_valid === 1'h1) capq.push_back(cap);
		if (rx_valid === 1'h1) rxq.push_back(rx_data);
	end

	// Reset with the mode pins settled, then check the idle outputs
	task automatic do_reset(input logic m, input logic l);
		rst <= 1'h1;
		master <= m;
		rate_long <= l;
		run <= 1'h0;
		repeat (8) @(posedge clock);
		check({sdo, rx_valid, tx_ready, sck_oe, ws_oe}, {3'h1, m, m});
		rst <= 1'h0;
		nfr = 0;
		exp_bits = l ? 50 : 32;
		capq.delete();
		rxq.delete();
	endtask

	task automatic push(input int first, input int n);
		for (int i = 0; i < n; i++) begin
			tx_valid <= 1'h1;
			tx_data <= pat(first + i);
			@(posedge clock);
		end
		tx_valid <= 1'h0;
	endtask

	// Leading zero pairs are idle frames sent before the first pop
	task automatic expect_tx(input int first, input int n);
		bsap_pkg::bsap_frame_type got;
		int k;
		k = 0;
		while (k < n) begin
			while (capq.size() == 0) @(posedge clock);
			got = capq.pop_front();
			if (k > 0 || got !== '0) begin
				check(got, pat(first + k));
				k++;
			end
		end
	endtask

	task automatic expect_rx();
		while (rxq.size() < 3) @(posedge clock);
		check(rxq[2], send);
	endtask

	// Far side stalls while nine pairs are offered; the ninth is refused
	task automatic slave_fifo();
		do_reset(1'h0, 1'h0);
		push(0, 9);
		@(posedge clock);
		check(tx_ready, 1'h0);
		run <= 1'h1;
		expect_tx(0, 8);
		check(tx_ready, 1'h1);
		while (capq.size() == 0) @(posedge clock);
		check(capq.pop_front(), 32'h0000_0000);
		expect_rx();
	endtask

	task automatic master_run(input logic l);
		do_reset(1'h1, l);
		push(20, 2);
		expect_tx(20, 2);
		expect_rx();
		while (nfr < 4) @(posedge clock);
		check(pad_err, 1'h0);
	endtask

	initial begin
		slave_fifo();
		master_run(1'h0);
		master_run(1'h1);
		close_out();
	end
endmodule
